// file: logic/gpib_init.sv
// bus initialisation and device clear handling of the instrument bus port
//
// Contract
// - interface clear returns talker, listener, handshake and serial poll functions to their initial state.
// - clear resets handshakes, talker, listener, controller; part of service request only.
// - interface clear never starts device clear or device reset.
// - talker and listener reach idle within 100 us of interface clear.
// - non system-active controller goes idle within 100 us of interface clear.
// - interface clear keeps service request line, ends serial poll mode.
// - remote state survives interface clear.
// - universal clear acts on every device regardless of addressing.
// - device clear empties input buffer and output queue.
// - device clear resets parser, execution controller and response formatter.
// - device clear cancels interfering queued commands, pending reset included.
// - device clear discards coupled messages and queries awaiting execution.
// - device clear idles completion command tracking; no event bit set later.
// - device clear idles completion query tracking and clears message available.
// - after device clear message exchange idles, waiting for new messages.
// - device clear keeps settings, data, panel, operation and other status bits.
`timescale 1ns/1ps

module gpib_init (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ifc_b,
  input wire logic ren_b,
  input wire gpib_init_pkg::bus_byte_t bus_byte,
  input wire logic [4:0] my_addr,
  input wire logic sys_ctrl,
  input wire logic srq_req,
  input wire gpib_init_pkg::core_ev_t core_ev,
  output gpib_init_pkg::fn_state_t fn_state,
  output gpib_init_pkg::msg_state_t msg_state,
  output logic msg_clear,
  output logic trigger,
  output logic srq_o,
  output logic srq_oe
);

  // ==========================================================================
  // pin synchronisation
  logic [1:0] pin_lvl;
  logic ifc_act;
  logic ren_act;

  pin_sync #(
    .WIDTH(2)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pin({ren_b, ifc_b}),
    .level(pin_lvl)
  );

  assign ifc_act = ~pin_lvl[0];
  assign ren_act = ~pin_lvl[1];

  // ==========================================================================
  // state registers
  gpib_init_pkg::talk_st_t talk_r;
  gpib_init_pkg::talk_st_t talk_nxt;
  gpib_init_pkg::lstn_st_t lstn_r;
  gpib_init_pkg::lstn_st_t lstn_nxt;
  gpib_init_pkg::ctrl_st_t ctrl_r;
  gpib_init_pkg::hs_st_t sh_r;
  gpib_init_pkg::hs_st_t ah_r;
  gpib_init_pkg::opc_st_t oc_r;
  gpib_init_pkg::opc_st_t oq_r;
  logic spms_r;
  logic remote_r;
  logic [gpib_init_pkg::CNT_W-1:0] ib_cnt_r;
  logic [gpib_init_pkg::CNT_W-1:0] oq_cnt_r;
  logic esr_opc_r;
  logic rst_pend_r;
  logic cpl_pend_r;
  logic clear_r;
  logic trig_r;
  logic srq_r;

  // ==========================================================================
  // command decode
  logic cmd_v;
  logic data_v;
  logic [7:0] cb;
  logic my_listen;
  logic my_talk;
  logic other_talk;
  logic is_unl;
  logic is_unt;
  logic lstn_addr;
  logic dcl_hit;
  logic sdc_hit;
  logic dev_clr;

  assign cb = bus_byte.data;
  assign cmd_v = bus_byte.valid & bus_byte.atn;
  assign data_v = bus_byte.valid & ~bus_byte.atn;
  assign my_listen = cmd_v & (cb[7:5] == gpib_init_pkg::GRP_LISTEN) & (cb[4:0] == my_addr);
  assign my_talk = cmd_v & (cb[7:5] == gpib_init_pkg::GRP_TALK) & (cb[4:0] == my_addr);
  assign other_talk = cmd_v & (cb[7:5] == gpib_init_pkg::GRP_TALK) & (cb[4:0] != my_addr);
  assign is_unl = cmd_v & (cb == gpib_init_pkg::CMD_UNL);
  assign is_unt = cmd_v & (cb == gpib_init_pkg::CMD_UNT);
  assign lstn_addr = (lstn_r != gpib_init_pkg::L_IDLE);
  assign dcl_hit = cmd_v & (cb == gpib_init_pkg::CMD_DCL);
  assign sdc_hit = cmd_v & (cb == gpib_init_pkg::CMD_SDC) & lstn_addr;
  // interface clear is not a source of device clear
  assign dev_clr = (dcl_hit | sdc_hit) & ~ifc_act;

  // ==========================================================================
  // talker function
  always_comb begin
    talk_nxt = talk_r;
    case (talk_r)
      gpib_init_pkg::T_IDLE: begin
        if (my_talk) begin
          talk_nxt = gpib_init_pkg::T_ADDR;
        end
      end
      gpib_init_pkg::T_ADDR, gpib_init_pkg::T_ACTIVE: begin
        if (is_unt || other_talk) begin
          talk_nxt = gpib_init_pkg::T_IDLE;
        end else if (bus_byte.valid) begin
          talk_nxt = bus_byte.atn ? gpib_init_pkg::T_ADDR : talk_r;
        end else if (!bus_byte.atn) begin
          talk_nxt = gpib_init_pkg::T_ACTIVE;
        end
      end
      default: talk_nxt = gpib_init_pkg::T_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      talk_r <= gpib_init_pkg::T_IDLE;
    end else if (ifc_act) begin
      talk_r <= gpib_init_pkg::T_IDLE;
    end else begin
      talk_r <= talk_nxt;
    end
  end

  // ==========================================================================
  // listener function
  always_comb begin
    lstn_nxt = lstn_r;
    case (lstn_r)
      gpib_init_pkg::L_IDLE: begin
        if (my_listen) begin
          lstn_nxt = gpib_init_pkg::L_ADDR;
        end
      end
      gpib_init_pkg::L_ADDR, gpib_init_pkg::L_ACTIVE: begin
        if (is_unl) begin
          lstn_nxt = gpib_init_pkg::L_IDLE;
        end else if (bus_byte.valid) begin
          lstn_nxt = bus_byte.atn ? gpib_init_pkg::L_ADDR : gpib_init_pkg::L_ACTIVE;
        end
      end
      default: lstn_nxt = gpib_init_pkg::L_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      lstn_r <= gpib_init_pkg::L_IDLE;
    end else if (ifc_act) begin
      lstn_r <= gpib_init_pkg::L_IDLE;
    end else begin
      lstn_r <= lstn_nxt;
    end
  end

  // ==========================================================================
  // controller function
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ctrl_r <= gpib_init_pkg::C_IDLE;
    end else if (ifc_act) begin
      // the system controller keeps or regains control, others idle
      ctrl_r <= sys_ctrl ? gpib_init_pkg::C_SYS_ACTIVE : gpib_init_pkg::C_IDLE;
    end else if (cmd_v && cb == gpib_init_pkg::CMD_TCT) begin
      if (talk_r != gpib_init_pkg::T_IDLE) begin
        ctrl_r <= gpib_init_pkg::C_ACTIVE;
      end else if (ctrl_r != gpib_init_pkg::C_SYS_ACTIVE) begin
        ctrl_r <= gpib_init_pkg::C_IDLE;
      end
    end
  end

  // ==========================================================================
  // source and acceptor handshakes
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      sh_r <= gpib_init_pkg::HS_IDLE;
    end else if (ifc_act) begin
      sh_r <= gpib_init_pkg::HS_IDLE;
    end else begin
      sh_r <= (talk_nxt == gpib_init_pkg::T_ACTIVE) ? gpib_init_pkg::HS_ARMED : gpib_init_pkg::HS_IDLE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ah_r <= gpib_init_pkg::HS_IDLE;
    end else if (ifc_act) begin
      ah_r <= gpib_init_pkg::HS_IDLE;
    end else begin
      ah_r <= (lstn_nxt != gpib_init_pkg::L_IDLE) ? gpib_init_pkg::HS_ARMED : gpib_init_pkg::HS_IDLE;
    end
  end

  // ==========================================================================
  // serial poll mode, the part of service request that clear touches
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      spms_r <= 1'b0;
    end else if (ifc_act) begin
      spms_r <= 1'b0;
    end else if (cmd_v && cb == gpib_init_pkg::CMD_SPE) begin
      spms_r <= 1'b1;
    end else if (cmd_v && cb == gpib_init_pkg::CMD_SPD) begin
      spms_r <= 1'b0;
    end
  end

  // service request line follows the status core only
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      srq_r <= 1'b0;
    end else begin
      srq_r <= srq_req;
    end
  end

  // ==========================================================================
  // remote and local, untouched by interface clear
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      remote_r <= 1'b0;
    end else if (!ren_act) begin
      remote_r <= 1'b0;
    end else if (my_listen) begin
      remote_r <= 1'b1;
    end else if (cmd_v && cb == gpib_init_pkg::CMD_GTL && lstn_addr) begin
      remote_r <= 1'b0;
    end
  end

  // ==========================================================================
  // device trigger, untouched by interface clear
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      trig_r <= 1'b0;
    end else begin
      trig_r <= cmd_v & (cb == gpib_init_pkg::CMD_GET) & lstn_addr;
    end
  end

  // ==========================================================================
  // message exchange reset pulse to parser, executor and formatter
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      clear_r <= 1'b0;
    end else begin
      clear_r <= dev_clr;
    end
  end

  // ==========================================================================
  // input buffer occupancy
  logic ib_push;
  logic ib_pop;

  assign ib_push = data_v & lstn_addr & (ib_cnt_r != gpib_init_pkg::CNT_W'(gpib_init_pkg::IBUF_DEPTH));
  assign ib_pop = core_ev.ib_pop & (ib_cnt_r != '0);

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      ib_cnt_r <= '0;
    end else if (dev_clr) begin
      ib_cnt_r <= '0;
    end else if (ib_push && !ib_pop) begin
      ib_cnt_r <= ib_cnt_r + 1'b1;
    end else if (ib_pop && !ib_push) begin
      ib_cnt_r <= ib_cnt_r - 1'b1;
    end
  end

  // ==========================================================================
  // output queue occupancy; a completion reply counts as one entry
  logic oq_push;
  logic oq_pop;
  logic oq_full;

  assign oq_full = (oq_cnt_r == gpib_init_pkg::CNT_W'(gpib_init_pkg::OQ_DEPTH));
  assign oq_push = (core_ev.out_push | (oq_r == gpib_init_pkg::OPC_ARMED & core_ev.op_done)) & ~oq_full;
  assign oq_pop = core_ev.out_pop & (talk_r == gpib_init_pkg::T_ACTIVE) & (oq_cnt_r != '0);

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      oq_cnt_r <= '0;
    end else if (dev_clr) begin
      oq_cnt_r <= '0;
    end else if (oq_push && !oq_pop) begin
      oq_cnt_r <= oq_cnt_r + 1'b1;
    end else if (oq_pop && !oq_push) begin
      oq_cnt_r <= oq_cnt_r - 1'b1;
    end
  end

  // ==========================================================================
  // completion command tracking
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      oc_r <= gpib_init_pkg::OPC_IDLE;
    end else if (dev_clr) begin
      oc_r <= gpib_init_pkg::OPC_IDLE;
    end else if (core_ev.opc_cmd) begin
      oc_r <= gpib_init_pkg::OPC_ARMED;
    end else if (core_ev.op_done) begin
      oc_r <= gpib_init_pkg::OPC_IDLE;
    end
  end

  // event bit is sticky and survives device clear
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      esr_opc_r <= 1'b0;
    end else if (oc_r == gpib_init_pkg::OPC_ARMED && core_ev.op_done && !dev_clr) begin
      esr_opc_r <= 1'b1;
    end
  end

  // ==========================================================================
  // completion query tracking
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      oq_r <= gpib_init_pkg::OPC_IDLE;
    end else if (dev_clr) begin
      oq_r <= gpib_init_pkg::OPC_IDLE;
    end else if (core_ev.opc_query) begin
      oq_r <= gpib_init_pkg::OPC_ARMED;
    end else if (core_ev.op_done) begin
      oq_r <= gpib_init_pkg::OPC_IDLE;
    end
  end

  // ==========================================================================
  // pending reset and coupled messages
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rst_pend_r <= 1'b0;
    end else if (dev_clr) begin
      rst_pend_r <= 1'b0;
    end else if (core_ev.rst_cmd) begin
      rst_pend_r <= 1'b1;
    end else if (core_ev.rst_done) begin
      rst_pend_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      cpl_pend_r <= 1'b0;
    end else if (dev_clr) begin
      cpl_pend_r <= 1'b0;
    end else if (core_ev.cpl_cmd) begin
      cpl_pend_r <= 1'b1;
    end else if (core_ev.cpl_done) begin
      cpl_pend_r <= 1'b0;
    end
  end

  // ==========================================================================
  // outputs
  assign fn_state.talker = talk_r;
  assign fn_state.listener = lstn_r;
  assign fn_state.ctrl = ctrl_r;
  assign fn_state.src_hs = sh_r;
  assign fn_state.acc_hs = ah_r;
  assign fn_state.serial_poll = spms_r;
  assign fn_state.remote = remote_r;
  assign msg_state.ib_count = ib_cnt_r;
  assign msg_state.oq_count = oq_cnt_r;
  // message available is the queue being non-empty
  assign msg_state.mav = (oq_cnt_r != '0);
  assign msg_state.esr_opc = esr_opc_r;
  assign msg_state.opc_cmd_st = oc_r;
  assign msg_state.opc_qry_st = oq_r;
  assign msg_state.rst_pend = rst_pend_r;
  assign msg_state.cpl_pend = cpl_pend_r;
  assign msg_clear = clear_r;
  assign trigger = trig_r;
  assign srq_o = 1'b0;
  assign srq_oe = srq_r;

endmodule

// file: logic/gpib_init_pkg.sv
// shared constants, states and carriers of the bus and device clear block
package gpib_init_pkg;

  // ==========================================================================
  // bus command codes, sent with attention true
  localparam logic [7:0] CMD_GTL = 8'h01;
  localparam logic [7:0] CMD_SDC = 8'h04;
  localparam logic [7:0] CMD_GET = 8'h08;
  localparam logic [7:0] CMD_TCT = 8'h09;
  localparam logic [7:0] CMD_DCL = 8'h14;
  localparam logic [7:0] CMD_SPE = 8'h18;
  localparam logic [7:0] CMD_SPD = 8'h19;
  localparam logic [7:0] CMD_UNL = 8'h3f;
  localparam logic [7:0] CMD_UNT = 8'h5f;
  localparam logic [2:0] GRP_LISTEN = 3'h1;
  localparam logic [2:0] GRP_TALK = 3'h2;

  // ==========================================================================
  // buffer sizes and timing
  localparam int IBUF_DEPTH = 16;
  localparam int OQ_DEPTH = 16;
  localparam int CNT_W = 5;
  localparam int SYNC_STAGES = 2;
  localparam int IFC_IDLE_MAX_US = 100;
  localparam int CLK_MHZ = 50;
  localparam int IFC_IDLE_MAX_CYC = IFC_IDLE_MAX_US * CLK_MHZ;
  localparam int IFC_REACT_CYC = SYNC_STAGES + 1;

  // ==========================================================================
  // interface function states
  typedef enum logic [1:0] {T_IDLE, T_ADDR, T_ACTIVE} talk_st_t;
  typedef enum logic [1:0] {L_IDLE, L_ADDR, L_ACTIVE} lstn_st_t;
  typedef enum logic [1:0] {C_IDLE, C_ACTIVE, C_SYS_ACTIVE} ctrl_st_t;
  typedef enum logic {HS_IDLE, HS_ARMED} hs_st_t;
  typedef enum logic {OPC_IDLE, OPC_ARMED} opc_st_t;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic valid;
    logic atn;
    logic [7:0] data;
  } bus_byte_t;

  typedef struct packed {
    logic ib_pop;
    logic out_push;
    logic out_pop;
    logic opc_cmd;
    logic opc_query;
    logic op_done;
    logic rst_cmd;
    logic rst_done;
    logic cpl_cmd;
    logic cpl_done;
  } core_ev_t;

  typedef struct packed {
    talk_st_t talker;
    lstn_st_t listener;
    ctrl_st_t ctrl;
    hs_st_t src_hs;
    hs_st_t acc_hs;
    logic serial_poll;
    logic remote;
  } fn_state_t;

  typedef struct packed {
    logic [CNT_W-1:0] ib_count;
    logic [CNT_W-1:0] oq_count;
    logic mav;
    logic esr_opc;
    opc_st_t opc_cmd_st;
    opc_st_t opc_qry_st;
    logic rst_pend;
    logic cpl_pend;
  } msg_state_t;

endpackage

// file: logic/pin_sync.sv
// two-stage synchroniser for pin levels
`timescale 1ns/1ps

module pin_sync #(
  parameter int WIDTH = 2
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] pin,
  output logic [WIDTH-1:0] level
);

  // ==========================================================================
  // per bit flop pair, idle high since the pins are active low
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
          meta_r[i] <= 1'b1;
          sync_r[i] <= 1'b1;
        end else begin
          meta_r[i] <= pin[i];
          sync_r[i] <= meta_r[i];
        end
      end
    end
  endgenerate

  assign level = sync_r;

endmodule

// file: dv/gpib_init_properties.sv
// concurrent checks of the bus and device clear block
`timescale 1ns/1ps

// ==========
// checker
module gpib_init_properties (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ifc_b,
  input wire logic ren_b,
  input wire logic sys_ctrl,
  input wire gpib_init_pkg::bus_byte_t bus_byte,
  input wire gpib_init_pkg::core_ev_t core_ev,
  input wire gpib_init_pkg::fn_state_t fn_state,
  input wire gpib_init_pkg::msg_state_t msg_state,
  input wire logic msg_clear
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  logic cmd_v;
  logic lstn;
  assign cmd_v = bus_byte.valid && bus_byte.atn;
  assign lstn = fn_state.listener != gpib_init_pkg::L_IDLE;

  sequence ifc_seen;
    !ifc_b [*3];
  endsequence

  // ==========
  // assertions
  chk_ifc_tl_idle: assert property (ifc_seen |=> fn_state.talker == gpib_init_pkg::T_IDLE
    && fn_state.listener == gpib_init_pkg::L_IDLE) else $error("talker or listener not idle");
  chk_ifc_ctrl_role: assert property (ifc_seen |=> fn_state.ctrl ==
    ($past(sys_ctrl) ? gpib_init_pkg::C_SYS_ACTIVE : gpib_init_pkg::C_IDLE)) else $error("controller state wrong");
  chk_ifc_poll_hs: assert property (ifc_seen |=> !fn_state.serial_poll &&
    fn_state.src_hs == gpib_init_pkg::HS_IDLE && fn_state.acc_hs == gpib_init_pkg::HS_IDLE)
    else $error("poll or handshake kept");
  chk_keep_remote: assert property (!ifc_b && !ren_b && !cmd_v && fn_state.remote |=>
    fn_state.remote) else $error("remote lost");
  chk_ifc_msg_keep: assert property (!ifc_b && !bus_byte.valid && core_ev == '0 |=>
    $stable(msg_state)) else $error("message state moved");
  chk_clear_cause: assert property (!bus_byte.valid |=> !msg_clear) else $error("clear without byte");
  chk_dcl_clear: assert property (ifc_b [*3] ##0 (cmd_v && bus_byte.data == gpib_init_pkg::CMD_DCL)
    |=> msg_clear && msg_state.ib_count == '0 && msg_state.oq_count == '0 && !msg_state.mav)
    else $error("universal clear incomplete");
  chk_sdc_addr: assert property (ifc_b [*3] ##0 (cmd_v && bus_byte.data == gpib_init_pkg::CMD_SDC
    && lstn) |=> msg_clear) else $error("selective clear missed");
  chk_sdc_refuse: assert property (cmd_v && bus_byte.data == gpib_init_pkg::CMD_SDC && !lstn
    |=> !msg_clear) else $error("selective clear not refused");
  chk_clear_idle: assert property (msg_clear |-> msg_state.opc_cmd_st == gpib_init_pkg::OPC_IDLE
    && msg_state.opc_qry_st == gpib_init_pkg::OPC_IDLE && !msg_state.rst_pend && !msg_state.cpl_pend)
    else $error("tracking not idle");
  chk_clear_esr: assert property (msg_clear |-> msg_state.esr_opc == $past(msg_state.esr_opc))
    else $error("event bit changed");

  // ==========
  // covers
  cov_clear: cover property (msg_clear);
  cov_sys: cover property (ifc_seen ##1 fn_state.ctrl == gpib_init_pkg::C_SYS_ACTIVE);
  cov_pass: cover property (fn_state.ctrl == gpib_init_pkg::C_ACTIVE);
endmodule

bind gpib_init gpib_init_properties i_chk (
  .sys_clk(sys_clk),
  .rst_b(rst_b),
  .ifc_b(ifc_b),
  .ren_b(ren_b),
  .sys_ctrl(sys_ctrl),
  .bus_byte(bus_byte),
  .core_ev(core_ev),
  .fn_state(fn_state),
  .msg_state(msg_state),
  .msg_clear(msg_clear)
);

// file: dv/bus_ctl_model.sv
// model of the system controller on the instrument bus
`timescale 1ns/1ps

// ==========
// controller model
module bus_ctl_model (
  input wire logic sys_clk,
  output logic ifc_b,
  output logic ren_b,
  output gpib_init_pkg::bus_byte_t bus_byte
);
  initial begin
    ifc_b = 1'b1;
    ren_b = 1'b1;
    bus_byte = '0;
  end

  // one accepted byte, data line scrambled once released
  task automatic send(input logic atn, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    bus_byte = '{valid: 1'b1, atn: atn, data: d};
    @(posedge sys_clk);
    #1;
    bus_byte.valid = 1'b0;
    bus_byte.data = ~d;
  endtask

  task automatic set_ren(input logic lvl_b);
    @(posedge sys_clk);
    #1;
    ren_b = lvl_b;
  endtask

  // only this model drives the clear line, low then released
  task automatic pulse_ifc(input int n);
    @(posedge sys_clk);
    #1;
    ifc_b = 1'b0;
    repeat (n) @(posedge sys_clk);
    #1;
    ifc_b = 1'b1;
  endtask

  task automatic dev_clear();
    send(1'b1, gpib_init_pkg::CMD_DCL);
  endtask

  // unlisten all, address target, then clear
  task automatic sel_clear(input logic [7:0] lsn);
    send(1'b1, gpib_init_pkg::CMD_UNL);
    send(1'b1, lsn);
    send(1'b1, gpib_init_pkg::CMD_SDC);
  endtask

  // bus clear first, then message clear
  task automatic full_init();
    pulse_ifc(gpib_init_pkg::IFC_IDLE_MAX_CYC);
    // let the synchronised clear level drop before the clear command
    repeat (gpib_init_pkg::SYNC_STAGES) @(posedge sys_clk);
    dev_clear();
  endtask
endmodule

// file: dv/gpib_init_test.sv
// self-checking bench of the bus and device clear block
`timescale 1ns/1ps

module gpib_init_test;
  localparam logic [7:0] LSN = 8'h23;
  localparam logic [7:0] TLK = 8'h43;
  localparam logic [9:0] E_PUSH = 10'h100;
  localparam logic [9:0] E_OPCC = 10'h040;
  localparam logic [9:0] E_OPCQ = 10'h020;
  localparam logic [9:0] E_DONE = 10'h010;
  localparam logic [9:0] E_RST = 10'h008;
  localparam logic [9:0] E_CPL = 10'h002;
  logic sys_clk;
  logic rst_b;
  logic ifc_b;
  logic ren_b;
  logic sys_ctrl;
  logic srq_req;
  logic msg_clear;
  logic trigger;
  logic srq_o;
  logic srq_oe;
  gpib_init_pkg::bus_byte_t bus_byte;
  gpib_init_pkg::core_ev_t core_ev;
  gpib_init_pkg::fn_state_t fn_state;
  gpib_init_pkg::msg_state_t msg_state;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;

  bus_ctl_model i_ctl (.sys_clk(sys_clk), .ifc_b(ifc_b), .ren_b(ren_b), .bus_byte(bus_byte));

  gpib_init i_dut (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .ifc_b(ifc_b),
    .ren_b(ren_b),
    .bus_byte(bus_byte),
    .my_addr(5'h03),
    .sys_ctrl(sys_ctrl),
    .srq_req(srq_req),
    .core_ev(core_ev),
    .fn_state(fn_state),
    .msg_state(msg_state),
    .msg_clear(msg_clear),
    .trigger(trigger),
    .srq_o(srq_o),
    .srq_oe(srq_oe)
  );

  // ==========
  // clock, timeout, helpers
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic ev(input logic [9:0] v);
    @(posedge sys_clk);
    #1;
    core_ev = v;
    @(posedge sys_clk);
    #1;
    core_ev = '0;
  endtask

  // ==========
  // scenarios
  task automatic t_dcl();
    ev(E_OPCC);
    ev(E_PUSH);
    i_ctl.dev_clear();
    check("dcl pulse", msg_clear, 1'b1);
    check("dcl oq", msg_state.oq_count, 5'h00);
    check("dcl mav", msg_state.mav, 1'b0);
    check("dcl oc", msg_state.opc_cmd_st, gpib_init_pkg::OPC_IDLE);
    ev(E_DONE);
    check("dcl esr", msg_state.esr_opc, 1'b0);
    ev(E_RST);
    check("rst after", msg_state.rst_pend, 1'b1);
  endtask

  task automatic t_sdc();
    i_ctl.send(1'b1, LSN);
    repeat (3) i_ctl.send(1'b0, 8'h41);
    check("ib fill", msg_state.ib_count, 5'h03);
    ev(E_OPCC);
    ev(E_DONE);
    check("esr set", msg_state.esr_opc, 1'b1);
    ev(E_PUSH | E_OPCC | E_OPCQ | E_RST | E_CPL);
    check("cpl pend", msg_state.cpl_pend, 1'b1);
    i_ctl.sel_clear(LSN);
    check("sdc pulse", msg_clear, 1'b1);
    check("sdc ib", msg_state.ib_count, 5'h00);
    check("sdc oq", msg_state.oq_count, 5'h00);
    check("sdc mav", msg_state.mav, 1'b0);
    check("sdc oc", msg_state.opc_cmd_st, gpib_init_pkg::OPC_IDLE);
    check("sdc oq st", msg_state.opc_qry_st, gpib_init_pkg::OPC_IDLE);
    check("sdc rst", msg_state.rst_pend, 1'b0);
    check("sdc cpl", msg_state.cpl_pend, 1'b0);
    check("sdc esr", msg_state.esr_opc, 1'b1);
    @(posedge sys_clk);
    #1;
    check("sdc end", msg_clear, 1'b0);
    ev(E_DONE);
    check("no reply", msg_state.oq_count, 5'h00);
  endtask

  task automatic t_sdc_refuse();
    i_ctl.send(1'b1, gpib_init_pkg::CMD_UNL);
    ev(E_PUSH);
    i_ctl.send(1'b1, gpib_init_pkg::CMD_SDC);
    check("sdc refused", msg_clear, 1'b0);
    check("oq kept", msg_state.oq_count, 5'h01);
  endtask

  task automatic t_ifc();
    srq_req = 1'b1;
    i_ctl.send(1'b1, LSN);
    i_ctl.send(1'b0, 8'h41);
    i_ctl.send(1'b1, gpib_init_pkg::CMD_GET);
    check("trigger", trigger, 1'b1);
    @(posedge sys_clk);
    #1;
    check("trigger end", trigger, 1'b0);
    i_ctl.send(1'b1, TLK);
    i_ctl.send(1'b1, gpib_init_pkg::CMD_TCT);
    i_ctl.send(1'b1, gpib_init_pkg::CMD_SPE);
    check("pre ctrl", fn_state.ctrl, gpib_init_pkg::C_ACTIVE);
    check("pre poll", fn_state.serial_poll, 1'b1);
    check("pre remote", fn_state.remote, 1'b1);
    sys_ctrl = 1'b0;
    i_ctl.pulse_ifc(gpib_init_pkg::IFC_IDLE_MAX_CYC);
    check("talker", fn_state.talker, gpib_init_pkg::T_IDLE);
    check("listener", fn_state.listener, gpib_init_pkg::L_IDLE);
    check("ctrl idle", fn_state.ctrl, gpib_init_pkg::C_IDLE);
    check("src hs", fn_state.src_hs, gpib_init_pkg::HS_IDLE);
    check("acc hs", fn_state.acc_hs, gpib_init_pkg::HS_IDLE);
    check("poll off", fn_state.serial_poll, 1'b0);
    check("srq kept", srq_oe, 1'b1);
    check("srq data", srq_o, 1'b0);
    check("remote", fn_state.remote, 1'b1);
    check("ib kept", msg_state.ib_count, 5'h01);
    sys_ctrl = 1'b1;
    i_ctl.full_init();
    check("sys ctrl", fn_state.ctrl, gpib_init_pkg::C_SYS_ACTIVE);
    check("dcl after", msg_state.ib_count, 5'h00);
    srq_req = 1'b0;
  endtask

  // ==========
  // main sequence
  initial begin
    rst_b = 1'b0;
    sys_ctrl = 1'b0;
    srq_req = 1'b0;
    core_ev = '0;
    repeat (6) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    check("reset msg", msg_state, 32'h0000_0000);
    check("reset srq", srq_oe, 1'b0);
    i_ctl.set_ren(1'b0);
    repeat (3) @(posedge sys_clk);
    t_dcl();
    t_sdc();
    t_sdc_refuse();
    t_ifc();
    final_report();
  end
endmodule
